// ===== common/arog_consts.vh
// Constants for the range, offset and gain register bank
// How it works
// - Range field bits 6:4 picks full scale 2g,4g,8g,16g,12g; 101-111 reserved. The 12g code shifts right by 2, the same as 8g.
// - Filter enable bit 3 clear bypasses the low-pass filter, set applies it.
// - Bandwidth field bits 2:0 picks cutoff divisor 4.255, 6, 12, 16; others reserved.
// - Results are two's complement, sign-extended, readable at 0x0d through 0x12.
// - X offset is signed: low byte 0x21, upper bits in 0x22 bits 6:0.
// - Y offset at 0x23/0x24 and Z offset at 0x25/0x26, same layout.
// - Offsets and gains load from OTP at init and reset; software may overwrite.
// - Each gain is unsigned nine bits; low byte at 0x27, 0x28, 0x29.
// - Gain top bit sits in bit 7 of each axis offset high register.
`ifndef AROG_CONSTS_VH
`define AROG_CONSTS_VH
// ==========================================
// Register offsets
`define AROG_ADDR_OUT_FIRST   8'h0d
`define AROG_ADDR_OUT_LAST    8'h12
`define AROG_ADDR_SCALE_CTRL  8'h20
`define AROG_ADDR_X_OFF_LOW   8'h21
`define AROG_ADDR_X_OFF_HIGH  8'h22
`define AROG_ADDR_Y_OFF_LOW   8'h23
`define AROG_ADDR_Y_OFF_HIGH  8'h24
`define AROG_ADDR_Z_OFF_LOW   8'h25
`define AROG_ADDR_Z_OFF_HIGH  8'h26
`define AROG_ADDR_X_GAIN_LOW  8'h27
`define AROG_ADDR_Y_GAIN_LOW  8'h28
`define AROG_ADDR_Z_GAIN_LOW  8'h29
// ==========================================
// Field positions and reset values
`define AROG_RANGE_HI         6
`define AROG_RANGE_LO         4
`define AROG_LOWPASS_ENABLE_BIT       3
`define AROG_LPF_HI           2
`define AROG_LPF_LO           0
`define AROG_SCALE_RESET      8'h00
`define AROG_SCALE_MASK       8'h7f
// ==========================================
// Range codes
`define AROG_RANGE_2G         3'h0
`define AROG_RANGE_4G         3'h1
`define AROG_RANGE_8G         3'h2
`define AROG_RANGE_16G        3'h3
`define AROG_RANGE_12G        3'h4
// Bandwidth codes
`define AROG_BW_DIV4P255      3'h1
`define AROG_BW_DIV6          3'h2
`define AROG_BW_DIV12         3'h3
`define AROG_BW_DIV16         3'h5
// Gain unity reference, 256 means x1
`define AROG_GAIN_SHIFT       8
`endif

// ===== logic/arog_axis_path.v
// One axis sample path: optional low-pass, offset, gain, range shift
`timescale 1ns/1ps
`default_nettype none
`include "arog_consts.vh"
module arog_axis_path #(
   parameter W = 16
) (
   input  wire          sys_clk_in,
   input  wire          resetn_in,
   input  wire          sample_valid_in,
   input  wire [W-1:0]  sample_in,
   input  wire          lowpass_enable_in,
   input  wire [2:0]    lowpass_bandwidth_sel_in,
   input  wire [2:0]    range_sel_in,
   input  wire [14:0]   offset_in,
   input  wire [8:0]    gain_in,
   output reg  [W-1:0]  result_out,
   output reg           result_valid_out
);
   // ==========================================
   // Filter
   reg  signed [W+3:0]  filt_q;
   reg  [2:0]           shift;
   wire signed [W+3:0]  smp_ext = {{4{sample_in[W-1]}}, sample_in};
   wire signed [W+3:0]  filt_d;
   always @*
   begin
      case (lowpass_bandwidth_sel_in)
         `AROG_BW_DIV4P255: shift = 3'd2;
         `AROG_BW_DIV6:     shift = 3'd3;
         `AROG_BW_DIV12:    shift = 3'd4;
         `AROG_BW_DIV16:    shift = 3'd4;
         default:           shift = 3'd2;
      endcase
   end
   // First order IIR approximates cutoff ratio
   assign filt_d = filt_q + ((smp_ext - filt_q) >>> shift);
   wire signed [W+3:0]  stage1 = lowpass_enable_in ? filt_d : smp_ext;
   // ==========================================
   // Offset, gain, range
   wire signed [W+3:0]  off_ext = {{(W-11){offset_in[14]}}, offset_in};
   wire signed [W+3:0]  biased  = stage1 + off_ext;
   wire signed [W+13:0] scaled  = biased * $signed({1'b0, gain_in});
   wire signed [W+13:0] unity   = scaled >>> `AROG_GAIN_SHIFT;
   reg  signed [W+13:0] ranged;
   always @*
   begin
      case (range_sel_in)
         `AROG_RANGE_2G:  ranged = unity;
         `AROG_RANGE_4G:  ranged = unity >>> 1;
         `AROG_RANGE_8G:  ranged = unity >>> 2;
         `AROG_RANGE_12G: ranged = unity >>> 2;
         `AROG_RANGE_16G: ranged = unity >>> 3;
         default:         ranged = unity;
      endcase
   end
   // Saturate so wrap never flips the sign
   wire signed [W+13:0] maxv = {{15{1'b0}}, {(W-1){1'b1}}};
   wire signed [W+13:0] minv = ~maxv;
   always @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         filt_q           <= {(W+4){1'b0}};
         result_out       <= {W{1'b0}};
         result_valid_out <= 1'b0;
      end
      else
      begin
         result_valid_out <= sample_valid_in;
         if (sample_valid_in)
         begin
            filt_q <= filt_d;
            if (ranged > maxv)
               result_out <= maxv[W-1:0];
            else if (ranged < minv)
               result_out <= minv[W-1:0];
            else
               result_out <= ranged[W-1:0];
         end
      end
   end
endmodule // arog_axis_path
`default_nettype wire

// ===== logic/arog_regs.v
// Range, filter, offset and gain register bank with three axis paths
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "arog_consts.vh"
module arog_regs #(
   parameter W = 16
) (
   input  wire          sys_clk_in,
   input  wire          resetn_in,
   input  wire [7:0]    addr_in,
   input  wire [7:0]    wdata_in,
   input  wire          wr_in,
   input  wire          rd_in,
   output reg  [7:0]    rdata_out,
   input  wire          otp_load_in,
   input  wire [14:0]   otp_x_offset_in,
   input  wire [14:0]   otp_y_offset_in,
   input  wire [14:0]   otp_z_offset_in,
   input  wire [8:0]    otp_x_gain_in,
   input  wire [8:0]    otp_y_gain_in,
   input  wire [8:0]    otp_z_gain_in,
   input  wire          sample_valid_in,
   input  wire [3*W-1:0] sample_in,
   output wire [3*W-1:0] result_out,
   output wire [2:0]    result_valid_out,
   output wire [2:0]    range_sel_out,
   output wire          lowpass_enable_out,
   output wire [2:0]    lowpass_bandwidth_sel_out
);
   // ==========================================
   // Registers
   reg  [7:0]   scale_q;
   reg  [14:0]  off_q  [0:2];
   reg  [8:0]   gain_q [0:2];
   reg          load_pend_q;
   assign range_sel_out             = scale_q[`AROG_RANGE_HI:`AROG_RANGE_LO];
   assign lowpass_enable_out        = scale_q[`AROG_LOWPASS_ENABLE_BIT];
   assign lowpass_bandwidth_sel_out = scale_q[`AROG_LPF_HI:`AROG_LPF_LO];
   wire [14:0]  otp_off  [0:2];
   wire [8:0]   otp_gain [0:2];
   assign otp_off[0]  = otp_x_offset_in;
   assign otp_off[1]  = otp_y_offset_in;
   assign otp_off[2]  = otp_z_offset_in;
   assign otp_gain[0] = otp_x_gain_in;
   assign otp_gain[1] = otp_y_gain_in;
   assign otp_gain[2] = otp_z_gain_in;
   // Reset cannot take port values, so load runs on first edge after release
   always @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         scale_q     <= `AROG_SCALE_RESET;
         load_pend_q <= 1'b1;
      end
      else
      begin
         load_pend_q <= 1'b0;
         if (wr_in && addr_in == `AROG_ADDR_SCALE_CTRL)
            scale_q <= wdata_in & `AROG_SCALE_MASK;
      end
   end
   // ==========================================
   // Per axis calibration
   genvar a;
   generate
      for (a = 0; a < 3; a = a + 1)
      begin : g_axis
         // Full width sums, cut to the byte address on purpose below
         localparam [31:0] OFF_LO_I  = `AROG_ADDR_X_OFF_LOW + 2*a;
         localparam [31:0] OFF_HI_I  = `AROG_ADDR_X_OFF_HIGH + 2*a;
         localparam [31:0] GAIN_LO_I = `AROG_ADDR_X_GAIN_LOW + a;
         wire [7:0] a_off_lo  = OFF_LO_I[7:0];
         wire [7:0] a_off_hi  = OFF_HI_I[7:0];
         wire [7:0] a_gain_lo = GAIN_LO_I[7:0];
         always @(posedge sys_clk_in or negedge resetn_in)
         begin
            if (!resetn_in)
            begin
               off_q[a]  <= 15'h0000;
               gain_q[a] <= 9'h100;
            end
            else if (load_pend_q || otp_load_in)
            begin
               off_q[a]  <= otp_off[a];
               gain_q[a] <= otp_gain[a];
            end
            else if (wr_in)
            begin
               if (addr_in == a_off_lo)
                  off_q[a][7:0] <= wdata_in;
               if (addr_in == a_off_hi)
               begin
                  off_q[a][14:8] <= wdata_in[6:0];
                  gain_q[a][8]   <= wdata_in[7];
               end
               if (addr_in == a_gain_lo)
                  gain_q[a][7:0] <= wdata_in;
            end
         end
         arog_axis_path #(.W(W)) u_path (
            .sys_clk_in               (sys_clk_in),
            .resetn_in                (resetn_in),
            .sample_valid_in          (sample_valid_in),
            .sample_in                (sample_in[a*W +: W]),
            .lowpass_enable_in        (scale_q[`AROG_LOWPASS_ENABLE_BIT]),
            .lowpass_bandwidth_sel_in (scale_q[`AROG_LPF_HI:`AROG_LPF_LO]),
            .range_sel_in             (scale_q[`AROG_RANGE_HI:`AROG_RANGE_LO]),
            .offset_in                (off_q[a]),
            .gain_in                  (gain_q[a]),
            .result_out               (result_out[a*W +: W]),
            .result_valid_out         (result_valid_out[a])
         );
      end
   endgenerate
   // ==========================================
   // Read port
   // Results read back little endian, X low byte at the first address
   wire [7:0] out_idx = addr_in - `AROG_ADDR_OUT_FIRST;
   wire [3*W-1:0] res_all = result_out;
   always @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         rdata_out <= 8'h00;
      else if (rd_in)
      begin
         if (addr_in >= `AROG_ADDR_OUT_FIRST && addr_in <= `AROG_ADDR_OUT_LAST)
            rdata_out <= res_all[out_idx[2:0]*8 +: 8];
         else
            case (addr_in)
               `AROG_ADDR_SCALE_CTRL: rdata_out <= scale_q;
               `AROG_ADDR_X_OFF_LOW:  rdata_out <= off_q[0][7:0];
               `AROG_ADDR_X_OFF_HIGH: rdata_out <= {gain_q[0][8], off_q[0][14:8]};
               `AROG_ADDR_Y_OFF_LOW:  rdata_out <= off_q[1][7:0];
               `AROG_ADDR_Y_OFF_HIGH: rdata_out <= {gain_q[1][8], off_q[1][14:8]};
               `AROG_ADDR_Z_OFF_LOW:  rdata_out <= off_q[2][7:0];
               `AROG_ADDR_Z_OFF_HIGH: rdata_out <= {gain_q[2][8], off_q[2][14:8]};
               `AROG_ADDR_X_GAIN_LOW: rdata_out <= gain_q[0][7:0];
               `AROG_ADDR_Y_GAIN_LOW: rdata_out <= gain_q[1][7:0];
               `AROG_ADDR_Z_GAIN_LOW: rdata_out <= gain_q[2][7:0];
               default:               rdata_out <= 8'h00;
            endcase
      end
   end
endmodule // arog_regs
`default_nettype wire

// ===== verification/arog_regs_props.sv
// Port checks for the register bank
`timescale 1ns/1ps
`default_nettype none
module arog_regs_chk #(
   parameter W = 16
) (
   input wire logic           sys_clk_in,
   input wire logic           resetn_in,
   input wire logic [7:0]     addr_in,
   input wire logic [7:0]     wdata_in,
   input wire logic           wr_in,
   input wire logic           rd_in,
   input wire logic [7:0]     rdata_out,
   input wire logic           otp_load_in,
   input wire logic [14:0]    otp_x_offset_in,
   input wire logic [8:0]     otp_x_gain_in,
   input wire logic           sample_valid_in,
   input wire logic [3*W-1:0] result_out,
   input wire logic [2:0]     result_valid_out,
   input wire logic [2:0]     range_sel_out,
   input wire logic           lowpass_enable_out,
   input wire logic [2:0]     lowpass_bandwidth_sel_out
);
   // ====================
   // Register bus
   wire logic [6:0] ctl_f = {range_sel_out, lowpass_enable_out, lowpass_bandwidth_sel_out};
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!resetn_in);
   property p_cw; wr_in && addr_in == 8'h20 |=> ctl_f == $past(wdata_in[6:0]); endproperty
   a_cw: assert property (p_cw) else $error("ctrl write");
   property p_cr; rd_in && addr_in == 8'h20 |=> rdata_out == {1'b0, ctl_f}; endproperty
   a_cr: assert property (p_cr) else $error("ctrl read");
   property p_wr; wr_in && !otp_load_in && addr_in inside {[8'h21:8'h29]}
      ##1 rd_in && addr_in == $past(addr_in) |=> rdata_out == $past(wdata_in, 2); endproperty
   a_wr: assert property (p_wr) else $error("cal readback");
   property p_ol; $past(otp_load_in) && rd_in && addr_in == 8'h22
      |=> rdata_out == {otp_x_gain_in[8], otp_x_offset_in[14:8]}; endproperty
   a_ol: assert property (p_ol) else $error("otp reload");
   // ====================
   // Sample path; a result read races a new sample, so old value
   property p_sv; sample_valid_in |=> result_valid_out == 3'b111; endproperty
   a_sv: assert property (p_sv) else $error("no result");
   property p_nv; !sample_valid_in |=> result_valid_out == 3'b000; endproperty
   a_nv: assert property (p_nv) else $error("stray result");
   property p_rl; rd_in && addr_in == 8'h0d |=> rdata_out == $past(result_out[7:0]); endproperty
   a_rl: assert property (p_rl) else $error("x low");
   property p_rh; rd_in && addr_in == 8'h12 |=> rdata_out == $past(result_out[3*W-1 -: 8]); endproperty
   a_rh: assert property (p_rh) else $error("z high");
endmodule // arog_regs_chk
bind arog_regs arog_regs_chk #(.W(W)) u_chk (.sys_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
   .rdata_out, .otp_load_in, .otp_x_offset_in, .otp_x_gain_in, .sample_valid_in, .result_out,
   .result_valid_out, .range_sel_out, .lowpass_enable_out, .lowpass_bandwidth_sel_out);
`default_nettype wire

// ===== verification/arog_tb.sv
// Directed tests of the register bank
`timescale 1ns/1ps
`default_nettype none
`define E @(posedge sys_clk_in)
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
   // ====================
   // Ports and arbitrary calibration contents
   logic        sys_clk_in = 1'b0;
   logic        resetn_in, wr_in, rd_in, otp_load_in, sample_valid_in;
   logic [7:0]  addr_in, wdata_in;
   logic [47:0] sample_in;
   wire  [7:0]  rdata_out;
   wire  [47:0] result_out;
   wire  [2:0]  result_valid_out, range_sel_out, lowpass_bandwidth_sel_out;
   wire         lowpass_enable_out;
   logic [14:0] off [3] = '{15'h5a3c, 15'h0f0f, 15'h7001};
   logic [8:0]  gain [3] = '{9'h1ab, 9'h0cd, 9'h100};
   logic [7:0]  ctl [5] = '{8'h09, 8'h12, 8'h2b, 8'h35, 8'h49};
   logic [7:0]  cal [9] = '{8'h00, 8'h80, 8'h00, 8'hff, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
   int          bad_count = 0, check_count = 0, cyc = 0;
   arog_regs DUT (.sys_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .otp_load_in,
      .otp_x_offset_in(off[0]), .otp_y_offset_in(off[1]), .otp_z_offset_in(off[2]), .otp_x_gain_in(gain[0]),
      .otp_y_gain_in(gain[1]), .otp_z_gain_in(gain[2]), .sample_valid_in, .sample_in, .result_out,
      .result_valid_out, .range_sel_out, .lowpass_enable_out, .lowpass_bandwidth_sel_out);
   initial forever #5 sys_clk_in = ~sys_clk_in;
   // Hang guard; the tests need well under 500 cycles
   always `E if (++cyc == 2000) end_of_test(1);
   // ====================
   // Bus access and closing
   task automatic end_of_test(input int hang);
      bad_count += hang;
      $display("%0d checks, %0d mismatches", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Starts just after an edge; an idle edge after release keeps strobes apart
   task automatic acc(input logic [7:0] a, d, input bit w = 1'b0, rb = 1'b0);
      {wr_in, rd_in, addr_in, wdata_in} <= {w, !w, a, d};
      `E;
      if (w && rb)
      begin
         {wr_in, rd_in} <= 2'b01;
         `E;
      end
      {wr_in, rd_in} <= 2'b00;
      `E;
      if (!w || rb)
         `CHK(rdata_out, d)
   endtask
   // ====================
   // Scenarios
   task automatic t_otp();
      for (logic [7:0] i = 0; i < 3; i++)
      begin
         acc(8'h21 + i + i, off[i][7:0]);
         acc(8'h22 + i + i, {gain[i][8], off[i][14:8]});
         acc(8'h27 + i, gain[i][7:0]);
      end
      acc(8'h20, 8'h00);
      $display("otp test done");
   endtask
   task automatic t_cal();
      for (logic [7:0] a = 8'h21; a < 8'h2a; a++)
      begin
         acc(a, a ^ 8'ha5, 1'b1, 1'b1);
      end
      otp_load_in <= 1'b1;
      `E;
      otp_load_in <= 1'b0;
      acc(8'h22, {gain[0][8], off[0][14:8]});
      $display("calibration test done");
   endtask
   task automatic t_rmw();
      logic [7:0] v;
      acc(8'h22, {gain[0][8], off[0][14:8]});
      v = {rdata_out[7], 7'h15};
      acc(8'h22, v, 1'b1);
      acc(8'h22, {gain[0][8], 7'h15});
      acc(8'h27, gain[0][7:0]);
      $display("read-modify-write test done");
   endtask
   task automatic t_rst();
      acc(8'h27, 8'h3c, 1'b1);
      resetn_in <= 1'b0;
      `E;
      `CHK({rdata_out, result_valid_out, range_sel_out}, 14'h0000)
      resetn_in <= 1'b1;
      `E;
      acc(8'h27, gain[0][7:0]);
      acc(8'h20, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_ctrl();
      foreach (ctl[i])
      begin
         acc(8'h20, ctl[i], 1'b1, 1'b1);
         `CHK({range_sel_out, lowpass_enable_out, lowpass_bandwidth_sel_out}, ctl[i][6:0])
      end
      acc(8'h20, 8'hff, 1'b1);
      acc(8'h20, 8'h7f);
      $display("control test done");
   endtask
   task automatic t_samp();
      acc(8'h20, 8'h00, 1'b1);
      foreach (cal[i])
         acc(8'h21 + 8'(i), cal[i], 1'b1);
      sample_valid_in <= 1'b1;
      `E;
      sample_valid_in <= 1'b0;
      `E;
      `CHK(result_valid_out, 3'b111)
      `CHK({result_out[47:32], result_out[15:0]}, 32'h0)
      `CHK({result_out[31], result_out[31:16] == 16'h0}, 2'b10)
      acc(8'h0d, 8'h00);
      acc(8'h0f, 8'h00);
      acc(8'h10, 8'hff);
      acc(8'h12, 8'h00);
      // Doubling full scale halves the counts
      acc(8'h20, 8'h10, 1'b1);
      sample_in <= 48'h0000_0000_0100;
      sample_valid_in <= 1'b1;
      `E;
      sample_valid_in <= 1'b0;
      `E;
      `CHK(result_out[15:0], 16'h0080)
      `CHK(result_out[31:16], 16'hff80)
      $display("sample test done");
   endtask
   initial
   begin
      {resetn_in, wr_in, rd_in, otp_load_in, sample_valid_in, addr_in, wdata_in, sample_in} = '0;
      repeat (10) `E;
      resetn_in <= 1'b1;
      `E;
      t_otp();
      t_cal();
      t_rmw();
      t_ctrl();
      t_rst();
      t_samp();
      end_of_test(0);
   end
endmodule // testbench
`default_nettype wire
